// ---- dv/efc_cpu_model.sv ----
`timescale 1ns/10ps
module efc_cpu_model (
	// Clock
	input wire logic clk_sys,
	// Program-space move port
	input wire logic cpuHalt,
	output logic [12:0] memAddr,
	output logic [7:0] memWdata,
	output logic memWr,
	output logic memRd,
	input wire logic [7:0] memRdata
);
	initial begin
		memAddr = 13'h0000;
		memWdata = 8'h00;
		memWr = 1'b0;
		memRd = 1'b0;
	end
	// A halted core issues nothing, so a move first sits out any erase stall.
	task automatic move(input logic wr, input logic [12:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		while (cpuHalt !== 1'b0) @(posedge clk_sys);
		memAddr <= a;
		memWdata <= d;
		memWr <= wr;
		memRd <= ~wr;
		@(posedge clk_sys);
		memWr <= 1'b0;
		memRd <= 1'b0;
		// Released lines show the inverse so stale values never look valid.
		memAddr <= ~a;
		memWdata <= ~d;
		@(posedge clk_sys);
		q = memRdata;
	endtask : move
endmodule : efc_cpu_model

// ---- dv/embedded_flash_user_program_control_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nMismatch++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module embedded_flash_user_program_control_tb;
	logic clk_sys, resetn, regWr, regRd, vppHigh, toolRd, toolChipErase, toolSetReadProtect;
	logic toolWr, toolSetHardLock;
	logic [7:0] toolWdata;
	logic memWr, memRd, cpuHalt, toolDataOut, toolDataOe, othersReset, busy, hardLocked;
	logic [1:0] regAddr;
	logic [7:0] regWdata, regRdata, memWdata, memRdata, toolRdata, q;
	logic [12:0] memAddr, toolAddr;
	int nMismatch = 0, nTests = 0, cyc = 0, haltCyc = 0, busyCyc = 0, h0;
	efc_flash_ctrl #(.SECTORS(64), .ERASE_CYC(20), .CHIP_ERASE_CYC(20), .PROG_CYC(5)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memAddr(memAddr),
		.memWdata(memWdata), .memWr(memWr), .memRd(memRd), .memRdata(memRdata),
		.cpuHalt(cpuHalt), .vppHigh(vppHigh), .toolAddr(toolAddr), .toolWdata(toolWdata),
		.toolWr(toolWr), .toolRd(toolRd), .toolChipErase(toolChipErase),
		.toolSetReadProtect(toolSetReadProtect), .toolSetHardLock(toolSetHardLock),
		.toolRdata(toolRdata), .toolDataOut(toolDataOut), .toolDataOe(toolDataOe),
		.othersReset(othersReset), .busy(busy), .hardLocked(hardLocked));
	efc_cpu_model cpu (.clk_sys(clk_sys), .cpuHalt(cpuHalt), .memAddr(memAddr),
		.memWdata(memWdata), .memWr(memWr), .memRd(memRd), .memRdata(memRdata));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// The whole run needs well under a thousand cycles.
	always @(posedge clk_sys) begin
		cyc++;
		haltCyc += int'(cpuHalt === 1'b1);
		busyCyc += int'(busy === 1'b1);
		if (cyc == 3000) begin
			nMismatch++;
			end_sim();
		end
	end
	task automatic rw(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : rw
	task automatic rr(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(posedge clk_sys);
		`CHK("register", e, regRdata)
	endtask : rr
	task automatic waitIdle;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk_sys);
	endtask : waitIdle
	task automatic toolRead(input logic [7:0] e);
		@(posedge clk_sys);
		toolAddr <= 13'h0310;
		toolRd <= 1'b1;
		@(posedge clk_sys);
		toolRd <= 1'b0;
		@(posedge clk_sys);
		`CHK("tool drive", 1'b1, toolDataOe)
		`CHK("tool data", e, toolRdata)
		`CHK("tool line", e[7], toolDataOut)
	endtask : toolRead
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		{resetn, regWr, regRd, vppHigh, toolRd, toolChipErase, toolSetReadProtect} = 7'h00;
		{toolWr, toolSetHardLock} = 2'h0;
		toolWdata = 8'h00;
		regAddr = 2'h0;
		regWdata = 8'h00;
		toolAddr = 13'h0000;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		rr(2'h1, 8'h00);
		rr(2'h0, 8'h00);
		$display("reset values done");
		rw(2'h1, 8'ha5);
		rw(2'h3, 8'h03);
		rw(2'h2, 8'h7f);
		h0 = haltCyc;
		rw(2'h0, 8'ha1);
		waitIdle();
		`CHK("halt length", 1'b1, haltCyc - h0 >= 20)
		rr(2'h0, 8'ha0);
		cpu.move(1'b0, 13'h0310, 8'h00, q);
		`CHK("erased byte", 8'hff, q)
		$display("sector erase done");
		rw(2'h0, 8'h51);
		h0 = busyCyc;
		cpu.move(1'b1, 13'h0310, 8'haa, q);
		waitIdle();
		`CHK("program time", 1'b1, busyCyc - h0 >= 5)
		cpu.move(1'b0, 13'h0310, 8'h00, q);
		`CHK("programmed byte", 8'haa, q)
		rw(2'h1, 8'ha4);
		cpu.move(1'b1, 13'h0311, 8'h00, q);
		waitIdle();
		cpu.move(1'b0, 13'h0311, 8'h00, q);
		`CHK("locked byte", 8'hff, q)
		$display("programming done");
		rw(2'h1, 8'h00);
		rw(2'h0, 8'ha1);
		repeat (30) @(posedge clk_sys);
		`CHK("no erase", 1'b0, busy)
		rr(2'h0, 8'ha1);
		rw(2'h1, 8'ha5);
		waitIdle();
		cpu.move(1'b0, 13'h0310, 8'h00, q);
		`CHK("late erase", 8'hff, q)
		$display("pending start done");
		rw(2'h0, 8'h61);
		repeat (2) @(posedge clk_sys);
		`CHK("user lock", 1'b1, hardLocked)
		rr(2'h0, 8'h60);
		@(posedge clk_sys);
		vppHigh <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK("others held", 1'b1, othersReset)
		toolSetReadProtect <= 1'b1;
		@(posedge clk_sys);
		toolSetReadProtect <= 1'b0;
		toolRead(8'h00);
		@(posedge clk_sys);
		toolChipErase <= 1'b1;
		@(posedge clk_sys);
		toolChipErase <= 1'b0;
		waitIdle();
		toolRead(8'hff);
		`CHK("lock cleared", 1'b0, hardLocked)
		toolWdata <= 8'h5a;
		toolWr <= 1'b1;
		@(posedge clk_sys);
		toolWr <= 1'b0;
		waitIdle();
		toolRead(8'h5a);
		toolSetHardLock <= 1'b1;
		@(posedge clk_sys);
		toolSetHardLock <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK("tool lock", 1'b1, hardLocked)
		$display("tool mode done");
		end_sim();
	end
endmodule : embedded_flash_user_program_control_tb

// ---- rtl/efc_flash_ctrl.sv ----
`timescale 1ns/10ps
module efc_flash_ctrl #(
	parameter int SECTORS = 64,
	parameter int ERASE_CYC = efc_pkg::ERASE_CYCLES,
	parameter int CHIP_ERASE_CYC = efc_pkg::CHIP_ERASE_CYCLES,
	parameter int PROG_CYC = efc_pkg::PROGRAM_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// CPU program-space move port
	input wire logic [12:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic memWr,
	input wire logic memRd,
	output logic [7:0] memRdata,
	output logic cpuHalt,
	// Tool mode side
	input wire logic vppHigh,
	input wire logic [12:0] toolAddr,
	input wire logic [7:0] toolWdata,
	input wire logic toolWr,
	input wire logic toolRd,
	input wire logic toolChipErase,
	input wire logic toolSetReadProtect,
	input wire logic toolSetHardLock,
	output logic [7:0] toolRdata,
	output logic toolDataOut,
	output logic toolDataOe,
	output logic othersReset,
	output logic busy,
	output logic hardLocked
);
	localparam int DEPTH = SECTORS * 128;
	localparam int AW = $clog2(DEPTH);
	localparam int SW = AW - efc_pkg::SECTOR_BITS;

	typedef struct packed {
		efc_pkg::efc_state_e st;
		logic [7:0] ctrl;
		logic [7:0] key;
		logic [7:0] secLow;
		logic [7:0] secHigh;
		logic [31:0] cnt;
		logic [AW-1:0] addr;
		logic [7:0] data;
		logic readProt;
		logic hardLock;
		logic tool;
		logic halt;
		logic [7:0] regRdata;
		logic [7:0] memRdata;
		logic [7:0] toolRdata;
		logic toolOe;
		logic toolOut;
	} efc_state_s;

	efc_state_s r_q, r_d;
	logic [7:0] mem [DEPTH];
	logic memWe;
	logic eraseSec;
	logic eraseAll;

	function automatic logic keyOk(input logic [7:0] k);
		keyOk = (k == efc_pkg::UNLOCK_KEY_VALUE);
	endfunction : keyOk

	function automatic logic [3:0] modeOf(input logic [7:0] c);
		modeOf = c[7:4];
	endfunction : modeOf

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		memWe = 1'b0;
		eraseSec = 1'b0;
		eraseAll = 1'b0;
		r_d.tool = vppHigh;
		r_d.toolOe = vppHigh && toolRd;
		r_d.toolOut = 1'b0;
		if (regWr && !r_q.tool) begin
			unique case (regAddr)
				efc_pkg::ADDR_CONTROL: begin
					// Software cannot clear the start bit while an erase runs; the erase clears it on completion.
					r_d.ctrl = {regWdata[7:1], regWdata[efc_pkg::START_BIT]
						| (r_q.ctrl[efc_pkg::START_BIT] && r_q.st == efc_pkg::ST_ERASE)};
				end
				efc_pkg::ADDR_UNLOCK_KEY: r_d.key = regWdata;
				efc_pkg::ADDR_SECTOR_LOW: r_d.secLow = regWdata;
				efc_pkg::ADDR_SECTOR_HIGH: r_d.secHigh = regWdata;
			endcase
		end
		if (regRd) begin
			unique case (regAddr)
				efc_pkg::ADDR_CONTROL: r_d.regRdata = r_q.ctrl;
				efc_pkg::ADDR_UNLOCK_KEY: r_d.regRdata = r_q.key;
				efc_pkg::ADDR_SECTOR_LOW: r_d.regRdata = r_q.secLow;
				efc_pkg::ADDR_SECTOR_HIGH: r_d.regRdata = r_q.secHigh;
			endcase
		end else begin
			r_d.regRdata = 8'h00;
		end
		if (memRd && !r_q.tool) begin
			r_d.memRdata = mem[memAddr[AW-1:0]];
		end
		if (toolRd && r_q.tool) begin
			r_d.toolRdata = r_q.readProt ? efc_pkg::PROTECTED_READ : mem[toolAddr[AW-1:0]];
			r_d.toolOut = r_d.toolRdata[7];
		end
		unique case (r_q.st)
			efc_pkg::ST_IDLE: begin
				r_d.cnt = '0;
				if (r_q.tool) begin
					if (toolChipErase) begin
						r_d.st = efc_pkg::ST_CHIP_ERASE;
					end else if (toolWr && !r_q.hardLock) begin
						r_d.addr = toolAddr[AW-1:0];
						r_d.data = toolWdata;
						r_d.st = efc_pkg::ST_TOOL_PROGRAM;
					end
					if (toolSetReadProtect) r_d.readProt = 1'b1;
					if (toolSetHardLock) r_d.hardLock = 1'b1;
				end else if (r_q.ctrl[efc_pkg::START_BIT] && keyOk(r_q.key)
					&& (modeOf(r_q.ctrl) == efc_pkg::MODE_ERASE
					|| modeOf(r_q.ctrl) == efc_pkg::MODE_HARDLOCK)) begin
					// A start bit left set in program mode must not shadow byte writes.
					// a start with a bad key is simply left pending.
					if (modeOf(r_q.ctrl) == efc_pkg::MODE_ERASE && !r_q.hardLock) begin
						r_d.addr = AW'({r_q.secHigh, r_q.secLow[7], 7'h00});
						r_d.halt = 1'b1;
						r_d.st = efc_pkg::ST_ERASE;
					end else if (modeOf(r_q.ctrl) == efc_pkg::MODE_HARDLOCK) begin
						r_d.hardLock = 1'b1;
						r_d.ctrl[efc_pkg::START_BIT] = 1'b0;
					end
				end else if (memWr && keyOk(r_q.key) && !r_q.hardLock
					&& modeOf(r_q.ctrl) == efc_pkg::MODE_PROGRAM) begin
					// the byte lands in the loaded sector.
					r_d.addr = AW'({r_q.secHigh, r_q.secLow[7],
						memAddr[efc_pkg::SECTOR_BITS-1:0]});
					r_d.data = memWdata;
					r_d.st = efc_pkg::ST_PROGRAM;
				end
			end
			efc_pkg::ST_ERASE: begin
				r_d.cnt = r_q.cnt + 32'h1;
				if (r_q.cnt == 32'(ERASE_CYC - 1)) begin
					eraseSec = 1'b1;
					r_d.halt = 1'b0;
					// A start written in the finishing cycle survives the self-clear.
					if (!(regWr && !r_q.tool && regAddr == efc_pkg::ADDR_CONTROL
						&& regWdata[efc_pkg::START_BIT])) begin
						r_d.ctrl[efc_pkg::START_BIT] = 1'b0;
					end
					r_d.st = efc_pkg::ST_IDLE;
				end
			end
			efc_pkg::ST_PROGRAM, efc_pkg::ST_TOOL_PROGRAM: begin
				r_d.cnt = r_q.cnt + 32'h1;
				if (r_q.cnt == 32'(PROG_CYC - 1)) begin
					memWe = 1'b1;
					r_d.st = efc_pkg::ST_IDLE;
				end
			end
			efc_pkg::ST_CHIP_ERASE: begin
				r_d.cnt = r_q.cnt + 32'h1;
				if (r_q.cnt == 32'(CHIP_ERASE_CYC - 1)) begin
					eraseAll = 1'b1;
					r_d.readProt = 1'b0;
					r_d.hardLock = 1'b0;
					r_d.st = efc_pkg::ST_IDLE;
				end
			end
			default: r_d.st = efc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r_q <= '0;
			r_q.st <= efc_pkg::ST_IDLE;
			r_q.ctrl <= efc_pkg::CTRL_RESET;
			r_q.key <= efc_pkg::KEY_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// Flash array, erased cells read all ones
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (eraseAll || (eraseSec && i[AW-1:efc_pkg::SECTOR_BITS]
				== r_q.addr[AW-1:efc_pkg::SECTOR_BITS])) begin
				mem[i] <= efc_pkg::ERASED_BYTE;
			end
		end
		if (memWe) mem[r_q.addr] <= mem[r_q.addr] & r_q.data;
	end

	assign regRdata = r_q.regRdata;
	assign memRdata = r_q.memRdata;
	assign toolRdata = r_q.toolRdata;
	assign toolDataOut = r_q.toolOut;
	assign toolDataOe = r_q.toolOe;
	assign othersReset = r_q.tool;
	assign cpuHalt = r_q.halt;
	assign busy = r_q.st != efc_pkg::ST_IDLE;
	assign hardLocked = r_q.hardLock;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence eraseStart;
		r_q.st == efc_pkg::ST_IDLE && r_d.st == efc_pkg::ST_ERASE;
	endsequence

	key_reset_a: assert property (@(posedge clk_sys) $rose(resetn) |-> r_q.key == 8'h00)
		else $error("key not cleared by reset");
	halt_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		eraseStart |=> cpuHalt [*8])
		else $error("cpu halt dropped early");
	bad_key_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!keyOk(r_q.key) |=> r_q.st != efc_pkg::ST_ERASE || $past(r_q.st) == efc_pkg::ST_ERASE)
		else $error("erase started without key");
	start_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.st == efc_pkg::ST_ERASE && r_d.st == efc_pkg::ST_IDLE |=> !r_q.ctrl[0])
		else $error("start bit not cleared");
	tool_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		vppHigh |=> othersReset)
		else $error("others not reset in tool mode");
	prot_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.tool && r_q.readProt && toolRd |=> toolRdata == 8'h00)
		else $error("protected read leaked data");
	oe_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		toolDataOe |-> $past(toolRd) && $past(vppHigh))
		else $error("data line driven outside read");
	no_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.st == efc_pkg::ST_IDLE && memWr && !keyOk(r_q.key) && !r_q.tool
		|=> r_q.st != efc_pkg::ST_PROGRAM)
		else $error("write accepted with bad key");
	unprot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		eraseAll |=> !r_q.readProt)
		else $error("read protect survived chip erase");

	// ----------------------------------------------------------------
	// Check helpers
	// ----------------------------------------------------------------
	// Run lengths let the timing checks count far beyond what a repetition can unroll.
	// They exist only for the checks below and feed no design logic.
	logic [31:0] haltRun;
	logic [31:0] busyRun;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			haltRun <= '0;
			busyRun <= '0;
		end else begin
			haltRun <= cpuHalt ? haltRun + 32'h1 : 32'h0;
			busyRun <= busy ? busyRun + 32'h1 : 32'h0;
		end
	end

	sequence eraseEnd;
		r_q.st == efc_pkg::ST_ERASE && r_d.st == efc_pkg::ST_IDLE;
	endsequence

	sequence programStart;
		r_q.st == efc_pkg::ST_IDLE && r_d.st == efc_pkg::ST_PROGRAM;
	endsequence

	// ----------------------------------------------------------------
	// Timing checks
	// ----------------------------------------------------------------
	// The halt must cover the whole erase, since a core running early would fetch from a
	// sector that is still being cleared.
	halt_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(cpuHalt) |-> haltRun == 32'(ERASE_CYC))
		else $error("erase halt length wrong");
	busy_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(busy) |-> busyRun >= 32'(PROG_CYC))
		else $error("operation ended too soon");
	halt_rise_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(cpuHalt) |-> r_q.st == efc_pkg::ST_ERASE)
		else $error("halt raised outside erase");
	halt_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		cpuHalt |-> busy)
		else $error("halt while idle");
	erase_done_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		eraseEnd |=> !cpuHalt)
		else $error("halt held after erase");

	// ----------------------------------------------------------------
	// Launch checks
	// ----------------------------------------------------------------
	erase_mode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		eraseStart |-> modeOf(r_q.ctrl) == efc_pkg::MODE_ERASE
		&& r_q.ctrl[efc_pkg::START_BIT] && keyOk(r_q.key))
		else $error("erase launched without request");
	sector_base_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		eraseStart |-> r_d.addr[efc_pkg::SECTOR_BITS-1:0] == '0)
		else $error("erase not on sector base");
	prog_key_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		programStart |-> keyOk(r_q.key) && !r_q.tool)
		else $error("program without key");
	write_mode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.st == efc_pkg::ST_IDLE && memWr && modeOf(r_q.ctrl) != efc_pkg::MODE_PROGRAM
		|=> r_q.st != efc_pkg::ST_PROGRAM)
		else $error("write accepted in wrong mode");
	lock_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.hardLock && r_q.st == efc_pkg::ST_IDLE
		|=> r_q.st != efc_pkg::ST_ERASE && r_q.st != efc_pkg::ST_PROGRAM)
		else $error("locked flash modified");

	// ----------------------------------------------------------------
	// Register checks
	// ----------------------------------------------------------------
	reg_frozen_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.tool && regWr |=> $stable(r_q.key) && $stable(r_q.secLow)
		&& $stable(r_q.secHigh))
		else $error("register written in tool mode");
	key_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		regRd && regAddr == efc_pkg::ADDR_UNLOCK_KEY |=> regRdata == $past(r_q.key))
		else $error("key read back wrong");
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!regRd |=> regRdata == '0)
		else $error("read data outside read cycle");

	// ----------------------------------------------------------------
	// Tool mode checks
	// ----------------------------------------------------------------
	// Tool mode follows the programming voltage, so leaving it must free the other modules.
	tool_leave_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!vppHigh |=> !othersReset)
		else $error("others held outside tool mode");
	tool_no_erase_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.tool && r_q.st == efc_pkg::ST_IDLE |=> r_q.st != efc_pkg::ST_ERASE)
		else $error("sector erase in tool mode");
	oe_tool_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		toolDataOe |-> othersReset)
		else $error("data line driven in user mode");
	tool_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		toolDataOe && $past(r_q.tool) |-> toolDataOut == toolRdata[7])
		else $error("data line disagrees with read");
	lock_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_q.tool && r_q.st == efc_pkg::ST_IDLE && toolSetHardLock |=> r_q.hardLock)
		else $error("tool hard lock not set");
	chip_unlock_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		eraseAll |=> !r_q.hardLock)
		else $error("hard lock survived chip erase");
	prot_source_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(r_q.readProt) |-> $past(r_q.tool))
		else $error("read protect set in user mode");
endmodule : efc_flash_ctrl

// ---- rtl/efc_pkg.sv ----
// Operation
// - Array holds 64 or 32 sectors of 128 bytes.
// - Erase whole sector, program single byte.
// - Sector erase lasts at least 8 ms.
// - Byte program lasts at least 25 us.
// - Tool mode holds other modules in reset.
// - Tool mode: chip erase, locks, no sector erase.
// - Read protect set in tool mode, reads 00.
// - Only tool chip erase clears read protect; here reset clears it too.
// - Tool data line driven on reads only.
// - Programming voltage detect enters tool mode.
// - User mode: erase, program, read, hard lock.
// - Control register selects operation, user mode only.
// - Start bit one launches erase or lock.
// - Erase halts CPU at least 4 ms.
// - Read and program ignore the start bit.
// - Unlock key resets to zero.
// - Only key 10100101 enables user mode.
// - Sector address low and high bytes.
// - Low address bits 6 to 0 ignored.
// - Program-space move instruction reads and writes.
// - Start bit self-clears after erase.
// - Start with bad key: no erase, bit stays.
package efc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_UNLOCK_KEY = 2'h1;
	localparam logic [1:0] ADDR_SECTOR_LOW = 2'h2;
	localparam logic [1:0] ADDR_SECTOR_HIGH = 2'h3;
	localparam logic [7:0] UNLOCK_KEY_VALUE = 8'ha5;
	localparam logic [7:0] KEY_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] MODE_ERASE = 4'ha;
	localparam logic [3:0] MODE_PROGRAM = 4'h5;
	localparam logic [3:0] MODE_HARDLOCK = 4'h6;
	localparam int START_BIT = 0;
	localparam int SECTOR_BITS = 7;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int ERASE_TIME_MS = 8;
	localparam int PROGRAM_TIME_US = 25;
	localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYCLES = ERASE_CYCLES;
	localparam logic [7:0] PROTECTED_READ = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ERASE,
		ST_PROGRAM,
		ST_CHIP_ERASE,
		ST_TOOL_PROGRAM
	} efc_state_e;
endpackage : efc_pkg
